//--- src/tig_regs.svh
// register offsets, field positions, reset values and counts of the timer interrupt gating block
`ifndef TIG_REGS_SVH
`define TIG_REGS_SVH

`define TIG_NSRC          9
`define TIG_NCHSRC        4
`define TIG_NMOD          2

`define TIG_OFF_CPUSTAT   8'h00
`define TIG_OFF_SRCEN     8'h04
`define TIG_OFF_FLAG      8'h08
`define TIG_OFF_PRIO0     8'h0C
`define TIG_OFF_PRIO1     8'h10
`define TIG_OFF_NMIEN     8'h14
`define TIG_OFF_STOP      8'h18
`define TIG_OFF_PROT      8'h1C
`define TIG_OFF_BPT_EN    8'h20
`define TIG_OFF_BPT_FLAG  8'h24
`define TIG_OFF_MFT_EN    8'h28
`define TIG_OFF_STATUS    8'h2C

`define TIG_CPU_GIE_BIT   0
`define TIG_CPU_IPL_LSB   4
`define TIG_FLAG_NMI_BIT  9
`define TIG_PROT_KEY_LSB  8
`define TIG_PROT_KEY      8'h5A
`define TIG_PROT_STOP_BIT 0
`define TIG_PROT_NMI_BIT  1
`define TIG_STOP_BPT_BIT  0
`define TIG_STOP_MFT_BIT  1

`define TIG_GIE_RST       1'h0
`define TIG_IPL_RST       4'h0
`define TIG_STOP_RST      2'h3
`define TIG_PROT_RST      2'h0

`endif

//--- src/tig_pkg.sv
// types shared by the timer interrupt gating block
package tig_pkg;
`include "tig_regs.svh"

    typedef logic [3:0]                           tig_prio_type;
    typedef logic [`TIG_NSRC-1:0][3:0]            tig_prio_vec_type;

    typedef struct packed {
        logic [`TIG_NCHSRC-1:0] en;
        logic [`TIG_NCHSRC-1:0] flag;
        logic [`TIG_NCHSRC-1:0] lvl;
    } tig_chan_state_type;

    typedef struct packed {
        logic                 gie;
        tig_prio_type         ipl;
        logic [`TIG_NSRC-1:0] srcEn;
        logic [`TIG_NSRC:0]   flag;
        tig_prio_vec_type     prio;
        logic                 nmiEn;
        logic [`TIG_NMOD-1:0] stop;
        logic [1:0]           prot;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        logic                 irqReq;
        logic [3:0]           irqVector;
        tig_prio_type         irqLevel;
        logic                 nmiReq;
    } tig_top_state_type;
endpackage

//--- src/tig_tmr_chan.sv
// peripheral side of one timer channel: request enables and optional request flags
`timescale 1ns/1ps
`include "tig_regs.svh"
module tig_tmr_chan #(
    parameter bit HAS_FLAGS = 1'b1
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    // module stop
    input  wire logic                         stopped,
    // channel events
    input  wire logic [`TIG_NCHSRC-1:0]       evt,
    // register access
    input  wire logic                         wrEn,
    input  wire logic                         wrClr,
    input  wire logic [`TIG_NCHSRC-1:0]       wdata,
    output logic      [`TIG_NCHSRC-1:0]       en,
    output logic      [`TIG_NCHSRC-1:0]       flag,
    // forwarded requests
    output logic      [`TIG_NCHSRC-1:0]       reqPulse
);
    import tig_pkg::*;

    tig_chan_state_type s_r;
    tig_chan_state_type s_nxt;

    always_comb begin
        s_nxt    = s_r;
        reqPulse = '0;
        if (wrEn) begin
            s_nxt.en = wdata;
        end
        if (HAS_FLAGS) begin
            if (wrClr) begin
                s_nxt.flag = s_r.flag & ~wdata;
            end
            s_nxt.flag = s_nxt.flag | (evt & {`TIG_NCHSRC{~stopped}});
            s_nxt.lvl  = s_nxt.flag & s_nxt.en;
            reqPulse   = s_nxt.lvl & ~s_r.lvl;
        end else begin
            s_nxt.flag = '0;
            s_nxt.lvl  = '0;
            reqPulse   = evt & s_r.en & {`TIG_NCHSRC{~stopped}};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign en   = s_r.en;
    assign flag = s_r.flag;
endmodule

//--- src/tig_prio_arb.sv
// picks the highest priority pending source and checks it against the processor level
`timescale 1ns/1ps
`include "tig_regs.svh"
module tig_prio_arb (
    // candidates
    input  wire logic [`TIG_NSRC-1:0]  pend,
    input  wire tig_pkg::tig_prio_vec_type prio,
    // processor state
    input  wire logic                  gie,
    input  wire tig_pkg::tig_prio_type ipl,
    // result
    output logic                       hit,
    output logic [3:0]                 vec,
    output tig_pkg::tig_prio_type      lvl
);
    import tig_pkg::*;

    always_comb begin
        vec = 4'h0;
        lvl = 4'h0;
        // strict compare keeps the lowest index on a tie
        for (int i = 0; i < `TIG_NSRC; i++) begin
            if (pend[i] && prio[i] != 4'h0 && prio[i] > lvl) begin
                lvl = prio[i];
                vec = 4'(i);
            end
        end
        hit = gie && (lvl != 4'h0) && (lvl > ipl);
    end
endmodule

//--- src/tig_top.sv
// timer interrupt gating controller with apb register access
//
// Functional notes
// - a maskable request is only accepted while the global enable flag is one.
// - a source is accepted only if enabled in the controller and given a non-zero priority.
// - a timer request is forwarded only when its enable inside the timer is set.
// - only requests with priority strictly above the four-bit processor level are accepted.
// - reset clears the global enable flag and sets the processor level to zero.
// - the controller holds the status flags of every source, the nmi included.
// - maskable sources use the controller enables, the nmi its own enable register.
// - the basic pulse timer holds enables and flags both in itself and in the controller.
// - the multifunction timer holds enables in both places but flags only in the controller.
// - each channel raises separate sources for compare a, compare b, overflow and underflow.
// - registers of a module in module stop can be neither read nor written.
// - reset places both timers in module stop; software releases them before setup.
// - a protect register guards groups of critical registers against writes.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "tig_regs.svh"

module tig_top (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,

    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,

    // timer and pin events
    input  wire logic [3:0]  basicEvt,
    input  wire logic [3:0]  multiEvt,
    input  wire logic        extPinEvt,
    input  wire logic        nmiEvt,

    // requests to the core
    output logic             irqReq,
    output logic [3:0]       irqVector,
    output logic [3:0]       irqLevel,
    output logic             nmiReq,

    // module stop to the timers
    output logic [1:0]       tmrStop
);
    import tig_pkg::*;

    tig_top_state_type s_r;
    tig_top_state_type s_nxt;

    // basic timer view
    logic [3:0]           bptEn;
    logic [3:0]           bptFlag;
    logic [3:0]           bptReq;
    logic                 wrBptEn;
    logic                 wrBptClr;

    // multifunction timer view
    logic [3:0]           mftEn;
    logic [3:0]           mftReq;
    logic                 wrMftEn;

    // arbiter result
    logic                 arbHit;
    logic [3:0]           arbVec;
    tig_prio_type         arbLvl;

    // controller pending
    logic [`TIG_NSRC-1:0] pend;

    // apb decode
    logic                 setup;
    logic                 wr;
    logic                 wrOk;

    function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
        regHit = (a == off);
    endfunction

    function automatic logic stoppedAddr(input logic [7:0] a, input logic [1:0] st);
        stoppedAddr = ((regHit(a, `TIG_OFF_BPT_EN) || regHit(a, `TIG_OFF_BPT_FLAG))
                       && st[`TIG_STOP_BPT_BIT])
                   || (regHit(a, `TIG_OFF_MFT_EN) && st[`TIG_STOP_MFT_BIT]);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= `TIG_OFF_STATUS);
    endfunction

    function automatic logic [31:0] statusWord(input logic rq, input logic nq,
                                               input logic [3:0] v, input logic [3:0] l);
        statusWord       = 32'h0000_0000;
        statusWord[0]    = rq;
        statusWord[1]    = nq;
        statusWord[7:4]  = v;
        statusWord[11:8] = l;
    endfunction

    // setup edge prepares read data; access edge commits writes
    assign setup = psel && !penable && !s_r.pready;
    assign wr    = psel && penable && s_r.pready && pwrite;
    assign wrOk  = wr
                && mapped(paddr)
                && !stoppedAddr(paddr, s_r.stop);

    // timer register strobes, already cleared of module stop
    assign wrBptEn  = wrOk && regHit(paddr, `TIG_OFF_BPT_EN);
    assign wrBptClr = wrOk && regHit(paddr, `TIG_OFF_BPT_FLAG);
    assign wrMftEn  = wrOk && regHit(paddr, `TIG_OFF_MFT_EN);

    // basic pulse timer keeps its own flags
    tig_tmr_chan #(
        .HAS_FLAGS (1'b1)
    ) u_bpt (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .stopped  (s_r.stop[`TIG_STOP_BPT_BIT]),
        .evt      (basicEvt),
        .wrEn     (wrBptEn),
        .wrClr    (wrBptClr),
        .wdata    (pwdata[3:0]),
        .en       (bptEn),
        .flag     (bptFlag),
        .reqPulse (bptReq)
    );

    tig_tmr_chan #(
        .HAS_FLAGS (1'b0)
    ) u_mft (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .stopped  (s_r.stop[`TIG_STOP_MFT_BIT]),
        .evt      (multiEvt),
        .wrEn     (wrMftEn),
        .wrClr    (1'b0),
        .wdata    (pwdata[3:0]),
        .en       (mftEn),
        .flag     (),
        .reqPulse (mftReq)
    );

    assign pend = s_r.flag[`TIG_NSRC-1:0] & s_r.srcEn;

    // highest pending source against the processor level
    tig_prio_arb u_arb (
        .pend (pend),
        .prio (s_r.prio),
        .gie  (s_r.gie),
        .ipl  (s_r.ipl),
        .hit  (arbHit),
        .vec  (arbVec),
        .lvl  (arbLvl)
    );

    always_comb begin
        logic [`TIG_NSRC:0] evtAll;
        logic [`TIG_NSRC:0] clrMask;
        s_nxt   = s_r;
        evtAll  = '0;
        clrMask = '0;

        // apb answer: pready for one cycle after each setup
        s_nxt.pready = setup;

        if (setup) begin
            s_nxt.prdata  = 32'h0000_0000;
            s_nxt.pslverr = !mapped(paddr) || stoppedAddr(paddr, s_r.stop);
            if (!s_nxt.pslverr && !pwrite) begin
                case (paddr)
                    `TIG_OFF_CPUSTAT: begin
                        s_nxt.prdata[`TIG_CPU_GIE_BIT] = s_r.gie;
                        s_nxt.prdata[`TIG_CPU_IPL_LSB +: 4] = s_r.ipl;
                    end

                    `TIG_OFF_SRCEN: begin
                        s_nxt.prdata[`TIG_NSRC-1:0] = s_r.srcEn;
                    end

                    `TIG_OFF_FLAG: begin
                        s_nxt.prdata[`TIG_NSRC:0] = s_r.flag;
                    end

                    `TIG_OFF_PRIO0: begin
                        s_nxt.prdata = s_r.prio[7:0];
                    end

                    `TIG_OFF_PRIO1: begin
                        s_nxt.prdata[3:0] = s_r.prio[8];
                    end

                    `TIG_OFF_NMIEN: begin
                        s_nxt.prdata[0] = s_r.nmiEn;
                    end

                    `TIG_OFF_STOP: begin
                        s_nxt.prdata[`TIG_NMOD-1:0] = s_r.stop;
                    end

                    `TIG_OFF_PROT: begin
                        s_nxt.prdata[1:0] = s_r.prot;
                    end

                    `TIG_OFF_BPT_EN: begin
                        s_nxt.prdata[3:0] = bptEn;
                    end

                    `TIG_OFF_BPT_FLAG: begin
                        s_nxt.prdata[3:0] = bptFlag;
                    end

                    `TIG_OFF_MFT_EN: begin
                        s_nxt.prdata[3:0] = mftEn;
                    end

                    `TIG_OFF_STATUS: begin
                        s_nxt.prdata = statusWord(s_r.irqReq, s_r.nmiReq, s_r.irqVector, s_r.irqLevel);
                    end

                    default: begin
                        s_nxt.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // register writes
        if (wrOk) begin
            case (paddr)
                `TIG_OFF_CPUSTAT: begin
                    s_nxt.gie = pwdata[`TIG_CPU_GIE_BIT];
                    s_nxt.ipl = pwdata[`TIG_CPU_IPL_LSB +: 4];
                end

                `TIG_OFF_SRCEN: begin
                    s_nxt.srcEn = pwdata[`TIG_NSRC-1:0];
                end

                `TIG_OFF_FLAG: begin
                    clrMask = pwdata[`TIG_NSRC:0];
                end

                `TIG_OFF_PRIO0: begin
                    for (int i = 0; i < 8; i++) begin
                        s_nxt.prio[i] = pwdata[4*i +: 4];
                    end
                end

                `TIG_OFF_PRIO1: begin
                    s_nxt.prio[8] = pwdata[3:0];
                end

                `TIG_OFF_NMIEN: begin
                    if (s_r.prot[`TIG_PROT_NMI_BIT]) begin
                        s_nxt.nmiEn = pwdata[0];
                    end
                end

                `TIG_OFF_STOP: begin
                    if (s_r.prot[`TIG_PROT_STOP_BIT]) begin
                        s_nxt.stop = pwdata[`TIG_NMOD-1:0];
                    end
                end

                `TIG_OFF_PROT: begin
                    if (pwdata[`TIG_PROT_KEY_LSB +: 8] == `TIG_PROT_KEY) begin
                        s_nxt.prot = pwdata[1:0];
                    end
                end

                default: begin
                end
            endcase
        end

        evtAll[3:0] = bptReq;
        evtAll[7:4] = mftReq;
        evtAll[8]   = extPinEvt;
        evtAll[`TIG_FLAG_NMI_BIT] = nmiEvt;

        s_nxt.flag = (s_r.flag & ~clrMask) | evtAll;

        // requests follow the flags by one edge
        s_nxt.irqReq    = arbHit;
        s_nxt.irqVector = arbHit ? arbVec : 4'h0;
        s_nxt.irqLevel  = arbHit ? arbLvl : 4'h0;

        s_nxt.nmiReq    = s_r.flag[`TIG_FLAG_NMI_BIT] && s_r.nmiEn;
    end

    // ce low holds every field, the apb answer included
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r      <= '0;
            s_r.gie  <= `TIG_GIE_RST;
            s_r.ipl  <= `TIG_IPL_RST;

            s_r.stop <= `TIG_STOP_RST;
            s_r.prot <= `TIG_PROT_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // every output straight from its flop
    assign prdata    = s_r.prdata;
    assign pready    = s_r.pready;
    assign pslverr   = s_r.pslverr;
    assign irqReq    = s_r.irqReq;
    assign irqVector = s_r.irqVector;
    assign irqLevel  = s_r.irqLevel;
    assign nmiReq    = s_r.nmiReq;
    assign tmrStop   = s_r.stop;
endmodule

//--- dv/tig_evt_src.sv
// partner model: timer channels, pin and nmi source giving one-cycle event pulses
`timescale 1ns/1ps
module tig_evt_src (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // bench command: index 0..8 a source, 9 the nmi
    input  wire logic       fire,
    input  wire logic [3:0] srcSel,
    // events to the controller
    output logic      [3:0] basicEvt,
    output logic      [3:0] multiEvt,
    output logic            extPinEvt,
    output logic            nmiEvt
);
    logic [9:0] pulse_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_r <= 10'h000;
        end else begin
            pulse_r <= fire ? 10'h001 << srcSel : 10'h000;
        end
    end
    assign basicEvt  = pulse_r[3:0];
    assign multiEvt  = pulse_r[7:4];
    assign extPinEvt = pulse_r[8];
    assign nmiEvt    = pulse_r[9];
endmodule

//--- dv/tig_top_assertions.sv
// concurrent checks on the ports of the timer interrupt gating top
`timescale 1ns/1ps
`include "tig_regs.svh"
module tig_top_assertions (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // events and requests
    input wire logic        nmiEvt,
    input wire logic        irqReq,
    input wire logic [3:0]  irqLevel,
    input wire logic        nmiReq,
    input wire logic [1:0]  tmrStop
);
    logic       wrHit;
    logic       gieSh_r;
    logic [3:0] iplSh_r;
    logic [1:0] protSh_r;
    logic       nmiEnSh_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // shadow of software writes, seen only at the pins
    assign wrHit = psel && penable && pready && pwrite && ce;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gieSh_r   <= 1'b0;
            iplSh_r   <= 4'h0;
            protSh_r  <= 2'h0;
            nmiEnSh_r <= 1'b0;
        end else if (wrHit) begin
            if (paddr == `TIG_OFF_CPUSTAT) begin
                gieSh_r <= pwdata[`TIG_CPU_GIE_BIT];
                iplSh_r <= pwdata[`TIG_CPU_IPL_LSB +: 4];
            end
            if (paddr == `TIG_OFF_NMIEN && protSh_r[`TIG_PROT_NMI_BIT]) begin
                nmiEnSh_r <= pwdata[0];
            end
            if (paddr == `TIG_OFF_PROT && pwdata[15:8] == `TIG_PROT_KEY) begin
                protSh_r <= pwdata[1:0];
            end
        end
    end

    sequence s_stop_locked;
        wrHit && paddr == `TIG_OFF_STOP && !protSh_r[`TIG_PROT_STOP_BIT];
    endsequence
    sequence s_timer_access;
        psel && penable && pready && (tmrStop[0] && (paddr == `TIG_OFF_BPT_EN
            || paddr == `TIG_OFF_BPT_FLAG) || tmrStop[1] && paddr == `TIG_OFF_MFT_EN);
    endsequence

    property p_gie_gate;
        irqReq |-> $past(gieSh_r);
    endproperty
    a_gie_gate: assert property (p_gie_gate)
        else $error("request accepted while global enable clear");
    property p_prio_given;
        irqReq |-> irqLevel != 4'h0;
    endproperty
    a_prio_given: assert property (p_prio_given)
        else $error("request accepted without a priority");
    property p_ipl_gate;
        irqReq |-> irqLevel > $past(iplSh_r);
    endproperty
    a_ipl_gate: assert property (p_ipl_gate)
        else $error("request level not above processor level");
    property p_rst_mask;
        $fell(rst) |-> !irqReq && !nmiReq && irqLevel == 4'h0;
    endproperty
    a_rst_mask: assert property (p_rst_mask)
        else $error("requests not masked after reset");
    property p_rst_stop;
        $fell(rst) |-> tmrStop == 2'h3;
    endproperty
    a_rst_stop: assert property (p_rst_stop)
        else $error("timers not stopped after reset");
    property p_stopped_refused;
        s_timer_access |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_stopped_refused: assert property (p_stopped_refused)
        else $error("stopped timer register answered");
    property p_protect;
        s_stop_locked |=> $stable(tmrStop) [*2];
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected stop register changed");
    property p_nmi_gate;
        nmiReq |-> $past(nmiEnSh_r);
    endproperty
    a_nmi_gate: assert property (p_nmi_gate)
        else $error("nmi request without its enable");
    property p_nmi_raise;
        nmiEvt && nmiEnSh_r |=> ##1 nmiReq;
    endproperty
    a_nmi_raise: assert property (p_nmi_raise)
        else $error("nmi event not raised");
    property p_flag_hold;
        irqReq && !(psel && pwrite) && !$past(psel && pwrite) |=> irqReq;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("request dropped without software clear");
endmodule

//--- dv/tig_top_tb.sv
// self-checking bench for the timer interrupt gating top
`timescale 1ns/1ps
`include "tig_regs.svh"
module tig_top_tb;
    logic        clk = 1'b0;
    logic        rst;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  basicEvt;
    logic [3:0]  multiEvt;
    logic        extPinEvt;
    logic        nmiEvt;
    logic        irqReq;
    logic [3:0]  irqVector;
    logic [3:0]  irqLevel;
    logic        nmiReq;
    logic [1:0]  tmrStop;
    logic        fire = 1'b0;
    logic [3:0]  srcSel = 4'h0;
    logic [32:0] expQ[$];
    int          failures = 0;
    int          n_tests = 0;
    int          seed = 82082;

    always #25 clk = ~clk;

    tig_top DUT (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .basicEvt(basicEvt), .multiEvt(multiEvt), .extPinEvt(extPinEvt),
        .nmiEvt(nmiEvt), .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel),
        .nmiReq(nmiReq), .tmrStop(tmrStop));
    tig_evt_src u_src (.clk(clk), .rst(rst), .fire(fire), .srcSel(srcSel),
        .basicEvt(basicEvt), .multiEvt(multiEvt), .extPinEvt(extPinEvt), .nmiEvt(nmiEvt));

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            failures++;
            tally_and_finish;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic e, input logic [31:0] d);
        expQ.push_back({e, d});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic ev(input logic [3:0] s);
        fire <= 1'b1;
        srcSel <= s;
        @(posedge clk);
        fire <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // read results leave at the access edge, oldest note first
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, expQ.size() > 0 ? expQ.pop_front() : 33'h1_FFFF_FFFF);
        end
    end

    initial begin
        logic [3:0] p;
        logic [3:0] ipl;
        logic       g;
        logic       en;
        logic [3:0] s;
        logic [31:0] st;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`TIG_OFF_CPUSTAT, 1'b0, 32'h0);
        rd(`TIG_OFF_STOP, 1'b0, 32'h3);
        check({31'h0, tmrStop}, 33'h3);
        rd(`TIG_OFF_BPT_EN, 1'b1, 32'h0);
        wr(`TIG_OFF_MFT_EN, 32'hF);
        rd(`TIG_OFF_MFT_EN, 1'b1, 32'h0);
        rd(8'h30, 1'b1, 32'h0);
        wr(`TIG_OFF_STOP, 32'h0);
        wr(`TIG_OFF_PROT, 32'h0000_A503);
        rd(`TIG_OFF_STOP, 1'b0, 32'h3);
        rd(`TIG_OFF_PROT, 1'b0, 32'h0);
        wr(`TIG_OFF_PROT, 32'h0000_5A03);
        wr(`TIG_OFF_STOP, 32'h0);
        rd(`TIG_OFF_STOP, 1'b0, 32'h0);
        check({31'h0, tmrStop}, 33'h0);
        rd(`TIG_OFF_MFT_EN, 1'b0, 32'h0);
        // passes: level just below, equal to, then random against the priority
        for (int k = 0; k < 27; k++) begin
            s = 4'(k % 9);
            p = 4'({$random(seed)} % 15 + 1);
            ipl = (k < 9) ? p - 4'h1 : (k < 18) ? p : 4'($random(seed));
            g = (k < 18) || $random(seed) % 2 != 0;
            en = (k < 18) || $random(seed) % 2 != 0;
            wr(`TIG_OFF_CPUSTAT, {24'h0, ipl, 3'h0, g});
            wr(`TIG_OFF_SRCEN, en ? 32'h1FF : 32'h1FF ^ (32'h1 << s));
            wr(`TIG_OFF_PRIO0, s < 8 ? 32'(p) << (4 * s) : 32'h0);
            wr(`TIG_OFF_PRIO1, s == 8 ? 32'(p) : 32'h0);
            if (s < 8) begin
                ev(s);
                rd(`TIG_OFF_FLAG, 1'b0, 32'h0);
                rd(`TIG_OFF_BPT_FLAG, 1'b0, s < 4 ? 32'h1 << s : 32'h0);
                wr(s < 4 ? `TIG_OFF_BPT_EN : `TIG_OFF_MFT_EN, 32'h1 << s[1:0]);
            end
            if (s > 3) begin
                ev(s);
            end
            rd(`TIG_OFF_FLAG, 1'b0, 32'h1 << s);
            st = g && en && p > ipl ? {20'h0, p, s, 4'h1} : 32'h0;
            rd(`TIG_OFF_STATUS, 1'b0, st);
            check({21'h0, irqLevel, irqVector, 2'h0, nmiReq, irqReq}, {1'b0, st});
            wr(`TIG_OFF_BPT_FLAG, 32'hF);
            wr(`TIG_OFF_FLAG, 32'h3FF);
            wr(`TIG_OFF_BPT_EN, 32'h0);
            wr(`TIG_OFF_MFT_EN, 32'h0);
        end
        ev(4'h9);
        rd(`TIG_OFF_FLAG, 1'b0, 32'h200);
        rd(`TIG_OFF_STATUS, 1'b0, 32'h0);
        wr(`TIG_OFF_NMIEN, 32'h1);
        rd(`TIG_OFF_STATUS, 1'b0, 32'h2);
        wr(`TIG_OFF_FLAG, 32'h200);
        ev(4'h9);
        rd(`TIG_OFF_STATUS, 1'b0, 32'h2);
        wr(`TIG_OFF_PROT, 32'h0000_5A00);
        wr(`TIG_OFF_NMIEN, 32'h0);
        rd(`TIG_OFF_NMIEN, 1'b0, 32'h1);
        tally_and_finish;
    end
endmodule

bind tig_top tig_top_assertions u_chk (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nmiEvt(nmiEvt), .irqReq(irqReq),
    .irqLevel(irqLevel), .nmiReq(nmiReq), .tmrStop(tmrStop));
